// *** hdl/usm_cfg.svh ***
// How it works
// - The regulator control output follows the low-voltage signalling enable bit directly.
// - Setting the enable bit from 0 to 1 starts moving card signalling from 3.3V to 1.8V.
// - A switch toward 1.8V is treated as complete once 5ms have passed since it began.
// - If the switch to 1.8V fails, the block clears the enable bit by itself.
// - Clearing the enable bit starts the return to 3.3V, complete after 5ms.
// - The bus speed mode field takes effect only while the enable bit is 1.
// - Mode codes: 001b SDR25, 010b SDR50, 011b SDR104, 100b DDR50, 101b to 111b reserved.
// - With presets enabled in SDR25, SDR50, SDR104 or DDR50, divider, clock source and drive type load from that mode's preset.
// - SDR50, SDR104 and DDR50 use the altered read-wait timing.
`ifndef USM_CFG_SVH
`define USM_CFG_SVH

// ==========================================
// Register map (byte addresses)
`define USM_ADDR_CTRL 12'h000
`define USM_ADDR_STAT 12'h004
`define USM_ADDR_PRE0 12'h008
`define USM_ADDR_STEP 12'h004
`define USM_ADDR_LAST 12'h01c

// ==========================================
// Control register fields
`define USM_MODE_LSB 0
`define USM_MODE_MSB 2
`define USM_LVSE_BIT 3
`define USM_DRV_LSB 4
`define USM_DRV_MSB 5
`define USM_PRESET_BIT 15
`define USM_CTRL_RESET 16'h0000

// ==========================================
// Preset register fields
`define USM_PRE_DIV_LSB 0
`define USM_PRE_DIV_MSB 9
`define USM_PRE_SRC_BIT 10
`define USM_PRE_DRV_LSB 14
`define USM_PRE_DRV_MSB 15
`define USM_PRESET_RESET 16'h0000

// ==========================================
// Timing
`define USM_CLK_HZ 20000000
`define USM_SETTLE_US 5000
`define USM_SETTLE_CYC ((`USM_CLK_HZ / 1000000) * `USM_SETTLE_US)

`endif

// *** hdl/usm_ctrl.sv ***
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "usm_cfg.svh"

module usm_ctrl
    import usm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Regulator and card status pins
    input wire logic switch_fail,
    output logic regulator_low_voltage,
    output logic signalling_settled,
    // Timing outputs
    output usm_mode_t bus_mode,
    output logic altered_read_wait,
    output usm_clk_cfg_t preset_cfg,
    output logic preset_active
);

    // ==========================================
    // Bus address phase capture
    logic wr_pend;
    logic [11:0] addr_q;
    logic next_wr_pend;
    logic [11:0] next_addr_q;

    // ==========================================
    // Control state
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] preset [0:3];
    logic [15:0] next_preset [0:3];
    usm_state_t state;
    usm_state_t next_state;
    logic [16:0] settle_cnt;
    logic [16:0] next_settle_cnt;
    logic fail_s1;
    logic fail_s2;
    logic lvse_q;
    logic [31:0] next_hrdata;

    localparam logic [16:0] SETTLE_CYC = 17'(`USM_SETTLE_CYC);

    logic lvse;
    logic [2:0] mode_code;
    logic [1:0] preset_idx;
    logic preset_hit;
    logic [15:0] sel_preset;

    assign lvse = ctrl[`USM_LVSE_BIT];
    assign mode_code = ctrl[`USM_MODE_MSB:`USM_MODE_LSB];

    // Always zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Mode decode, honoured only at low voltage; reserved codes fall back
    always_comb
    begin
        bus_mode = USM_DEFAULT;
        if (lvse)
        begin
            case (mode_code)
                3'h1: bus_mode = USM_SDR25;
                3'h2: bus_mode = USM_SDR50;
                3'h3: bus_mode = USM_SDR104;
                3'h4: bus_mode = USM_DDR50;
                default: bus_mode = USM_DEFAULT;
            endcase
        end
    end

    // Fast modes change read-wait timing
    assign altered_read_wait = (bus_mode == USM_SDR50) || (bus_mode == USM_SDR104)
        || (bus_mode == USM_DDR50);

    // Preset slot per mode: SDR25, SDR50, SDR104, DDR50
    always_comb
    begin
        preset_idx = 2'h0;
        preset_hit = 1'b1;
        case (bus_mode)
            USM_SDR25: preset_idx = 2'h0;
            USM_SDR50: preset_idx = 2'h1;
            USM_SDR104: preset_idx = 2'h2;
            USM_DDR50: preset_idx = 2'h3;
            default: preset_hit = 1'b0;
        endcase
    end

    assign sel_preset = preset[preset_idx];
    assign preset_active = ctrl[`USM_PRESET_BIT] && preset_hit;

    // Loaded clock settings; manual drive field when presets are off
    always_comb
    begin
        preset_cfg.divider = 10'h000;
        preset_cfg.clock_source = 1'b0;
        preset_cfg.drive_type = ctrl[`USM_DRV_MSB:`USM_DRV_LSB];
        if (preset_active)
        begin
            preset_cfg.divider = sel_preset[`USM_PRE_DIV_MSB:`USM_PRE_DIV_LSB];
            preset_cfg.clock_source = sel_preset[`USM_PRE_SRC_BIT];
            preset_cfg.drive_type = sel_preset[`USM_PRE_DRV_MSB:`USM_PRE_DRV_LSB];
        end
    end

    // Regulator follows the enable bit with no added delay
    assign regulator_low_voltage = lvse;
    assign signalling_settled = (state == USM_ST_HIGH) || (state == USM_ST_LOW);

    // Bus next-state: latch address phase, decode writes and reads
    always_comb
    begin
        next_wr_pend = 1'b0;
        next_addr_q = addr_q;
        next_ctrl = ctrl;
        next_hrdata = hrdata;
        for (int i = 0; i < 4; i++)
        begin
            next_preset[i] = preset[i];
        end
        if (hsel && hready && htrans[1])
        begin
            next_wr_pend = hwrite;
            next_addr_q = haddr;
        end
        if (wr_pend)
        begin
            if (addr_q == `USM_ADDR_CTRL)
            begin
                next_ctrl = hwdata[15:0];
            end
            else if (addr_q >= `USM_ADDR_PRE0 && addr_q <= `USM_ADDR_LAST)
            begin
                next_preset[addr_q[3:2]] = hwdata[15:0];
            end
        end
        // Failure clear wins over a write in the same cycle
        if (fail_s2 && state == USM_ST_TO_LOW)
        begin
            next_ctrl[`USM_LVSE_BIT] = 1'b0;
        end
        // Read data registered for the data phase; unmapped reads zero
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            next_hrdata = 32'h0000_0000;
            if (haddr == `USM_ADDR_CTRL)
            begin
                next_hrdata = {16'h0000, next_ctrl};
            end
            else if (haddr == `USM_ADDR_STAT)
            begin
                next_hrdata = {27'h0000000, bus_mode, state};
            end
            else if (haddr >= `USM_ADDR_PRE0 && haddr <= `USM_ADDR_LAST)
            begin
                next_hrdata = {16'h0000, next_preset[haddr[3:2]]};
            end
        end
    end

    // Voltage switch sequencer with settle timer
    always_comb
    begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        if (lvse && !lvse_q)
        begin
            next_state = USM_ST_TO_LOW;
            next_settle_cnt = SETTLE_CYC;
        end
        else if (!lvse && lvse_q)
        begin
            next_state = USM_ST_TO_HIGH;
            next_settle_cnt = SETTLE_CYC;
        end
        else
        begin
            case (state)
                USM_ST_TO_LOW, USM_ST_TO_HIGH:
                begin
                    if (settle_cnt <= 17'h00001)
                    begin
                        next_settle_cnt = 17'h00000;
                        next_state = (state == USM_ST_TO_LOW) ? USM_ST_LOW : USM_ST_HIGH;
                    end
                    else
                    begin
                        next_settle_cnt = settle_cnt - 17'h00001;
                    end
                end
                default: next_settle_cnt = 17'h00000;
            endcase
        end
    end

    // Register stage; reset leaves 3.3V default mode
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_pend <= 1'b0;
            addr_q <= 12'h000;
            ctrl <= `USM_CTRL_RESET;
            for (int i = 0; i < 4; i++)
            begin
                preset[i] <= `USM_PRESET_RESET;
            end
            state <= USM_ST_HIGH;
            settle_cnt <= 17'h00000;
            fail_s1 <= 1'b0;
            fail_s2 <= 1'b0;
            lvse_q <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            addr_q <= next_addr_q;
            ctrl <= next_ctrl;
            for (int i = 0; i < 4; i++)
            begin
                preset[i] <= next_preset[i];
            end
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            fail_s1 <= switch_fail; // Synchroniser, pin is asynchronous
            fail_s2 <= fail_s1;
            lvse_q <= lvse;
            hrdata <= next_hrdata;
        end
    end

endmodule

`default_nettype wire

// *** hdl/usm_pkg.sv ***
package usm_pkg;

    // Decoded bus timing modes
    typedef enum logic [2:0]
    {
        USM_DEFAULT = 3'h0,
        USM_SDR25 = 3'h1,
        USM_SDR50 = 3'h2,
        USM_SDR104 = 3'h3,
        USM_DDR50 = 3'h4
    } usm_mode_t;

    // Regulator sequencing states
    typedef enum logic [1:0]
    {
        USM_ST_HIGH,
        USM_ST_TO_LOW,
        USM_ST_LOW,
        USM_ST_TO_HIGH
    } usm_state_t;

    // Clock and drive settings handed to the clock generator
    typedef struct packed
    {
        logic [9:0] divider;
        logic clock_source;
        logic [1:0] drive_type;
    } usm_clk_cfg_t;

endpackage

// *** tb/ultra_high_speed_mode_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "usm_cfg.svh"
module ultra_high_speed_mode_control_tb
    import usm_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic fail_cmd = 1'b0, rd_dp = 1'b0, card_clock_output_enable = 1'b1;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rnd = 32'hbe5f, hrdata;
    logic hreadyout, hresp, switch_fail, regulator_low_voltage;
    logic signalling_settled, altered_read_wait, preset_active, accept;
    usm_mode_t bus_mode;
    usm_clk_cfg_t preset_cfg, ecfg;
    logic [31:0] exp_q[$];
    logic [15:0] pre[4], cw;
    int error_cnt = 0, checks_done = 0, cyc = 0, n, code;

    always #25 clk = ~clk;

    usm_ctrl i_usm_ctrl (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .switch_fail,
        .regulator_low_voltage, .signalling_settled, .bus_mode,
        .altered_read_wait, .preset_cfg, .preset_active);
    usm_card i_usm_card (.clk, .fail_cmd, .regulator_low_voltage, .switch_fail,
        .card_low_voltage_accept(accept));

    // ========================================
    // Helpers
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task print_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Single word transfer; read data noted for the monitor
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr;
        if (!wr)
            exp_q.push_back(d);
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    // Read data taken at the end of the data phase
    always @(posedge clk)
        if (rd_dp && hreadyout)
        begin
            check(hrdata, exp_q.pop_front());
            check(hresp, 1'b0);
        end

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 120000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        xfer(0, `USM_ADDR_CTRL, 0);
        xfer(0, `USM_ADDR_STAT, 0);
        for (int i = 0; i < 4; i++)
        begin
            pre[i] = 16'(xs()) & 16'hc7ff;
            xfer(1, `USM_ADDR_PRE0 + 12'(4 * i), {16'h0, pre[i]});
            xfer(0, `USM_ADDR_PRE0 + 12'(4 * i), {16'h0, pre[i]});
        end
        xfer(1, 12'h020, 32'hffff);
        xfer(0, 12'h020, 0);
        xfer(1, `USM_ADDR_CTRL, 32'h8002);
        @(negedge clk);
        check(bus_mode, USM_DEFAULT);
        check(preset_active, 0);
        check(accept, 1);
        xfer(1, `USM_ADDR_CTRL, 32'h0008);
        repeat (2) @(negedge clk);
        check(regulator_low_voltage, 1);
        check(signalling_settled, 0);
        // Every mode code, presets off then on
        for (int i = 0; i < 16; i++)
        begin
            code = i % 8;
            cw = {i[3], 9'h0, 2'(xs()), 1'b1, i[2:0]};
            card_clock_output_enable <= 1'b0;
            xfer(1, `USM_ADDR_CTRL, {16'h0, cw});
            card_clock_output_enable <= 1'b1;
            @(negedge clk);
            check(bus_mode, (code inside {[1:4]}) ? code : 0);
            check(altered_read_wait, code inside {[2:4]});
            check(preset_active, i[3] && code inside {[1:4]});
            n = (code + 1) % 4;
            ecfg = {pre[n][9:0], pre[n][10], pre[n][15:14]};
            if (!(i[3] && code inside {[1:4]}))
                ecfg = {11'h0, cw[5:4]};
            check(preset_cfg, ecfg);
        end
        xfer(0, `USM_ADDR_STAT, 32'h1);
        @(posedge clk);
        fail_cmd <= 1'b1;
        repeat (6) @(negedge clk);
        check(regulator_low_voltage, 0);
        @(posedge clk);
        fail_cmd <= 1'b0;
        xfer(0, `USM_ADDR_CTRL, {16'h0, cw & 16'hfff7});
        n = 0;
        while (signalling_settled !== 1'b1 && n < 110000)
        begin
            @(negedge clk);
            n++;
        end
        check(n >= 99900 && n <= 100000, 1);
        xfer(0, `USM_ADDR_STAT, 0);
        print_verdict();
    end
endmodule
`default_nettype wire

// *** tb/usm_card.sv ***
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Regulator and card side
module usm_card
#(
    parameter bit ACCEPT = 1'b1
)
(
    // Clock and command
    input wire logic clk,
    input wire logic fail_cmd,
    // Card pins
    input wire logic regulator_low_voltage,
    output logic switch_fail = 1'b0,
    output logic card_low_voltage_accept
);
    // Card answer to the low-level request
    assign card_low_voltage_accept = ACCEPT;
    // Model has no block-gap interrupt path, so fast modes stay legal
    // Fail only while the regulator is at low voltage, so no stale fail
    always_ff @(posedge clk)
        switch_fail <= fail_cmd & regulator_low_voltage;
endmodule
`default_nettype wire

// *** tb/usm_ctrl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "usm_cfg.svh"
// ========================================
// Checker on the mode and regulator pins
module usm_ctrl_props
    import usm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched pins
    input wire logic switch_fail,
    input wire logic regulator_low_voltage,
    input wire logic signalling_settled,
    input wire usm_mode_t bus_mode,
    input wire logic altered_read_wait,
    input wire logic preset_active
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Cycles since the regulator level last moved; saturates so it never wraps
    logic reg_prev;
    logic [16:0] settle_age;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reg_prev <= 1'b0;
            settle_age <= 17'h00000;
        end
        else
        begin
            reg_prev <= regulator_low_voltage;
            if (regulator_low_voltage != reg_prev)
                settle_age <= 17'h00000;
            else if (settle_age != 17'h1ffff)
                settle_age <= settle_age + 17'h00001;
        end
    end

    property p_settle;
        $rose(signalling_settled) |-> settle_age == 17'(`USM_SETTLE_CYC);
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle window not 5ms");
    property p_gate;
        !regulator_low_voltage |-> bus_mode == USM_DEFAULT;
    endproperty
    a_gate: assert property (p_gate)
        else $error("mode active at high level");
    property p_rsv;
        bus_mode <= USM_DDR50;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved mode decoded");
    property p_wait;
        altered_read_wait == (bus_mode inside {USM_SDR50, USM_SDR104, USM_DDR50});
    endproperty
    a_wait: assert property (p_wait)
        else $error("read wait timing wrong");
    property p_pre;
        preset_active |-> bus_mode != USM_DEFAULT;
    endproperty
    a_pre: assert property (p_pre)
        else $error("preset without mode");
    property p_low;
        $rose(regulator_low_voltage) |-> ##[1:2] !signalling_settled;
    endproperty
    a_low: assert property (p_low)
        else $error("no settle window to low");
    property p_high;
        $fell(regulator_low_voltage) |-> ##[1:2] !signalling_settled;
    endproperty
    a_high: assert property (p_high)
        else $error("no settle window to high");
    property p_fail;
        (switch_fail && regulator_low_voltage && !signalling_settled) [*2]
            |-> ##[0:3] !regulator_low_voltage;
    endproperty
    a_fail: assert property (p_fail)
        else $error("failed switch left enabled");
    property p_rst;
        $rose(resetn) |-> !regulator_low_voltage && signalling_settled;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset");
endmodule

bind usm_ctrl usm_ctrl_props i_usm_ctrl_props (
    .clk,
    .resetn,
    .switch_fail,
    .regulator_low_voltage,
    .signalling_settled,
    .bus_mode,
    .altered_read_wait,
    .preset_active
);
`default_nettype wire
